/* inc/cpsf_pkg.sv */
package cpsf_pkg;
  localparam logic [7:0] STATUS_ADDR_B0 = 8'h03;
  localparam logic [7:0] STATUS_ADDR_B1 = 8'h83;
  localparam logic [6:0] STATUS_LOW7 = 7'h03;
  localparam int BIT_IND_BANK = 7;
  localparam int BIT_DIR_HI = 6;
  localparam int BIT_DIR_LO = 5;
  localparam int BIT_EXPIRY = 4;
  localparam int BIT_SLEEP = 3;
  localparam int BIT_ZERO = 2;
  localparam int BIT_NIBBLE = 1;
  localparam int BIT_CARRY = 0;
  // Power-on value: banks 0, both reset-cause flags set
  localparam logic [7:0] POR_VALUE = 8'h18;
  // Flag-logic operation classes driven by the core decoder
  typedef enum logic [2:0] {
    CPSF_OP_NONE,
    CPSF_OP_ADD,
    CPSF_OP_SUB,
    CPSF_OP_LOGIC,
    CPSF_OP_CLEAR,
    CPSF_OP_ROT_LEFT,
    CPSF_OP_ROT_RIGHT
  } cpsf_op_e;
endpackage

/* src/cpsf_alu_flags.sv */
`timescale 1ns/100ps
`default_nettype none
module cpsf_alu_flags
(
  // Operands and operation class
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  input wire cpsf_pkg::cpsf_op_e op_i,
  input wire logic carry_in_i,
  // Result and flags
  output logic [7:0] result_o,
  output logic zero_o,
  output logic nibble_o,
  output logic carry_o,
  output logic upd_zero_o,
  output logic upd_nibble_o,
  output logic upd_carry_o
);
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [7:0] bop;
  logic is_add;
  logic is_sub;
  logic is_rl;
  logic is_rr;
  // Subtract by adding two's complement; carry then is not-borrow
  assign is_add = (op_i == cpsf_pkg::CPSF_OP_ADD);
  assign is_sub = (op_i == cpsf_pkg::CPSF_OP_SUB);
  assign is_rl = (op_i == cpsf_pkg::CPSF_OP_ROT_LEFT);
  assign is_rr = (op_i == cpsf_pkg::CPSF_OP_ROT_RIGHT);
  assign bop = is_sub ? ~b_i : b_i;
  assign sum9 = {1'b0, a_i} + {1'b0, bop} + {8'h00, is_sub};
  assign sum5 = {1'b0, a_i[3:0]} + {1'b0, bop[3:0]} + {4'h0, is_sub};
  assign nibble_o = sum5[4];
  assign carry_o = is_rl ? a_i[7] : (is_rr ? a_i[0] : sum9[8]);
  assign result_o = (is_add || is_sub) ? sum9[7:0] :
                    is_rl ? {a_i[6:0], carry_in_i} :
                    is_rr ? {carry_in_i, a_i[7:1]} :
                    (op_i == cpsf_pkg::CPSF_OP_CLEAR) ? 8'h00 : a_i;
  assign zero_o = (result_o == 8'h00);
  assign upd_nibble_o = is_add || is_sub;
  assign upd_carry_o = is_add || is_sub || is_rl || is_rr;
  assign upd_zero_o = is_add || is_sub ||
                      (op_i == cpsf_pkg::CPSF_OP_LOGIC) ||
                      (op_i == cpsf_pkg::CPSF_OP_CLEAR);
endmodule
`default_nettype wire

/* src/cpsf_status_reg.sv */
`timescale 1ns/100ps
`default_nettype none
module cpsf_status_reg
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Instruction execute port from the core
  input wire logic exec_i,
  input wire cpsf_pkg::cpsf_op_e op_i,
  input wire logic [7:0] opa_i,
  input wire logic [7:0] opb_i,
  input wire logic wr_en_i,
  input wire logic [7:0] wr_addr_i,
  input wire logic [7:0] rd_addr_i,
  // Core events
  input wire logic clrwdt_i,
  input wire logic sleep_i,
  input wire logic wdt_expire_i,
  // Readback and results
  output logic [7:0] status_o,
  output logic [7:0] rd_data_o,
  output logic rd_hit_o,
  output logic [7:0] result_o,
  output logic [8:0] indirect_base_o,
  output logic [7:0] direct_base_o
);
  logic [7:0] status_r;
  logic [7:0] status_nxt;
  logic [7:0] result_r;
  logic [7:0] rd_data_r;
  logic rd_hit_r;
  logic [7:0] alu_res;
  logic alu_z;
  logic alu_dc;
  logic alu_c;
  logic upd_z;
  logic upd_dc;
  logic upd_c;
  logic wr_hit;
  logic rd_hit;
  logic [7:0] sw_val;
  logic expiry_nxt;
  logic sleep_nxt;
  logic flag_op;
  logic [2:0] flag_wr;

  // Mirror decode: bank bit ignored so 03H and 83H share one register
  function automatic logic is_status(input logic [7:0] addr);
    is_status = (addr[6:0] == cpsf_pkg::STATUS_LOW7);
  endfunction

  cpsf_alu_flags cpsf_alu_flags_inst
  (
    .a_i(opa_i),
    .b_i(opb_i),
    .op_i(op_i),
    .carry_in_i(status_r[cpsf_pkg::BIT_CARRY]),
    .result_o(alu_res),
    .zero_o(alu_z),
    .nibble_o(alu_dc),
    .carry_o(alu_c),
    .upd_zero_o(upd_z),
    .upd_nibble_o(upd_dc),
    .upd_carry_o(upd_c)
  );

  // Address decode for writes and reads
  assign wr_hit = exec_i && wr_en_i && is_status(wr_addr_i);
  assign rd_hit = is_status(rd_addr_i);

  // Value software would store, before hardware masking
  assign sw_val = wr_hit ? alu_res : status_r;

  // Any flag-touching op blocks the write to all three flag bits;
  // otherwise a clear aimed here would wipe the carry flags
  assign flag_op = exec_i && (upd_z || upd_dc || upd_c);
  assign flag_wr = flag_op ? status_r[2:0] : sw_val[2:0];

  // Reset-cause flags: only core events move them
  assign expiry_nxt = wdt_expire_i ? 1'b0 :
                      (clrwdt_i || sleep_i) ? 1'b1 :
                      status_r[cpsf_pkg::BIT_EXPIRY];
  assign sleep_nxt = sleep_i ? 1'b0 :
                     clrwdt_i ? 1'b1 :
                     status_r[cpsf_pkg::BIT_SLEEP];

  // Bank bits from the write; flags from hardware win over the write
  assign status_nxt[7:5] = sw_val[7:5];
  assign status_nxt[cpsf_pkg::BIT_EXPIRY] = expiry_nxt;
  assign status_nxt[cpsf_pkg::BIT_SLEEP] = sleep_nxt;
  assign status_nxt[cpsf_pkg::BIT_ZERO] = (exec_i && upd_z) ? alu_z :
                                          flag_wr[cpsf_pkg::BIT_ZERO];
  assign status_nxt[cpsf_pkg::BIT_NIBBLE] = (exec_i && upd_dc) ? alu_dc :
                                    flag_wr[cpsf_pkg::BIT_NIBBLE];
  assign status_nxt[cpsf_pkg::BIT_CARRY] = (exec_i && upd_c) ? alu_c :
                                   flag_wr[cpsf_pkg::BIT_CARRY];

  // Status register; power-on value sets both reset-cause flags
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      status_r <= cpsf_pkg::POR_VALUE;
    else
      status_r <= status_nxt;
  end

  // Registered readback and result so outputs come from flops
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rd_data_r <= 8'h00;
      rd_hit_r <= 1'b0;
      result_r <= 8'h00;
    end
    else
    begin
      rd_data_r <= rd_hit ? status_nxt : 8'h00;
      rd_hit_r <= rd_hit;
      result_r <= exec_i ? alu_res : result_r;
    end
  end

  assign status_o = status_r;
  assign rd_data_o = rd_data_r;
  assign rd_hit_o = rd_hit_r;
  assign result_o = result_r;
  // Bank bases straight from the status flops
  assign indirect_base_o = {status_r[cpsf_pkg::BIT_IND_BANK], 8'h00};
  assign direct_base_o = {status_r[cpsf_pkg::BIT_DIR_LO], 7'h00};
endmodule
`default_nettype wire

/* test/cpsf_checker_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module cpsf_checker
(
  // Watched ports of the status register
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic exec_i,
  input wire cpsf_pkg::cpsf_op_e op_i,
  input wire logic wr_en_i,
  input wire logic [7:0] wr_addr_i,
  input wire logic clrwdt_i,
  input wire logic sleep_i,
  input wire logic wdt_expire_i,
  input wire logic [7:0] status_o,
  input wire logic [7:0] result_o,
  input wire logic [8:0] indirect_base_o,
  input wire logic [7:0] direct_base_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // Status write, no event; events would move the cause bits
  wire logic h = exec_i && wr_en_i && wr_addr_i[6:0] == 7'h03
    && !(clrwdt_i || sleep_i || wdt_expire_i);
  a_cause_ro: assert property (h |=> $stable(status_o[4:3]))
    else $error("cause bits written");
  a_bank_wr: assert property (h |=> status_o[7:5] == result_o[7:5])
    else $error("bank bits not written");
  a_clear_z: assert property (
    exec_i && op_i == cpsf_pkg::CPSF_OP_CLEAR |=> status_o[2])
    else $error("clear left zero low");
  a_sleep_fl: assert property (
    sleep_i && !wdt_expire_i |=> status_o[4:3] == 2'b10)
    else $error("sleep flags wrong");
  a_expiry: assert property (wdt_expire_i |=> !status_o[4])
    else $error("expiry flag high");
  a_clrwdt: assert property (
    clrwdt_i && !sleep_i && !wdt_expire_i |=> &status_o[4:3])
    else $error("clear flags wrong");
  a_ind_base: assert property (indirect_base_o == {status_o[7], 8'h00})
    else $error("indirect base wrong");
  a_dir_base: assert property (direct_base_o == {status_o[5], 7'h00})
    else $error("direct base wrong");
  // Main scenarios
  c_clear: cover property (exec_i && op_i == cpsf_pkg::CPSF_OP_CLEAR);
  c_sleep: cover property (sleep_i);
  c_expiry: cover property (wdt_expire_i);
endmodule
bind cpsf_status_reg cpsf_checker cpsf_checker_inst (.*);
`default_nettype wire

/* test/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk_i = 1'b0, nrst_i = 1'b0, exec_i = 1'b0, wr_en_i = 1'b0, rd_hit_o;
  logic clrwdt_i = 1'b0, sleep_i = 1'b0, wdt_expire_i = 1'b0;
  logic [7:0] opa_i = 8'h00, opb_i = 8'h00, wr_addr_i = 8'h00;
  logic [7:0] rd_addr_i = 8'h83, status_o, rd_data_o, result_o, direct_base_o;
  logic [8:0] indirect_base_o;
  cpsf_pkg::cpsf_op_e op_i = cpsf_pkg::CPSF_OP_NONE;
  int n_fail = 0, checked = 0;
  cpsf_status_reg cpsf_status_reg_inst
  (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .exec_i(exec_i),
    .op_i(op_i),
    .opa_i(opa_i),
    .opb_i(opb_i),
    .wr_en_i(wr_en_i),
    .wr_addr_i(wr_addr_i),
    .rd_addr_i(rd_addr_i),
    .clrwdt_i(clrwdt_i),
    .sleep_i(sleep_i),
    .wdt_expire_i(wdt_expire_i),
    .status_o(status_o),
    .rd_data_o(rd_data_o),
    .rd_hit_o(rd_hit_o),
    .result_o(result_o),
    .indirect_base_o(indirect_base_o),
    .direct_base_o(direct_base_o)
  );
  // 20 MHz core clock
  initial forever #25 clk_i = ~clk_i;
  task chk(input logic [8:0] s, input logic [8:0] e);
    checked++;
    if (s !== e) n_fail++;
    if (s !== e) $display("wrong value at %0t: %h not %h", $time, s, e);
  endtask
  // One exec cycle; f is write enable, clear, sleep, expiry
  task ex(input cpsf_pkg::cpsf_op_e o, input logic [7:0] a, b, d,
    input logic [3:0] f);
    @(posedge clk_i);
    op_i <= o;
    {opa_i, opb_i, wr_addr_i} <= {a, b, d};
    {exec_i, wr_en_i, clrwdt_i, sleep_i, wdt_expire_i} <= {1'b1, f};
    @(posedge clk_i);
    {exec_i, wr_en_i, clrwdt_i, sleep_i, wdt_expire_i} <= 5'h00;
    #1;
  endtask
  // Bank bits land, flags come from the flag logic or, with no flag op, from the write
  task t_write;
    ex(cpsf_pkg::CPSF_OP_ADD, 8'h3F, 8'h00, 8'h03, 4'h8);
    chk(status_o, 8'h38);
    chk({indirect_base_o[8], direct_base_o}, 9'h080);
    ex(cpsf_pkg::CPSF_OP_SUB, 8'h10, 8'h01, 8'h83, 4'h8);
    chk(status_o, 8'h19);
    ex(cpsf_pkg::CPSF_OP_ADD, 8'h0F, 8'h01, 8'h00, 4'h0);
    chk(status_o, 8'h1A);
    ex(cpsf_pkg::CPSF_OP_CLEAR, 8'h55, 8'h55, 8'h83, 4'h8);
    chk(status_o, 8'h1E);
    ex(cpsf_pkg::CPSF_OP_NONE, 8'h05, 8'h00, 8'h03, 4'h8);
    chk(status_o, 8'h1D);
    chk(rd_data_o, 8'h1D);
    chk(rd_hit_o, 1'b1);
  endtask
  // Rotates load carry, logic op clears zero, read miss
  task t_rot;
    ex(cpsf_pkg::CPSF_OP_ROT_RIGHT, 8'h02, 8'h00, 8'h00, 4'h0);
    chk(status_o, 8'h1C);
    chk(result_o, 8'h81);
    ex(cpsf_pkg::CPSF_OP_ROT_LEFT, 8'h80, 8'h00, 8'h00, 4'h0);
    chk(status_o, 8'h1D);
    chk(result_o, 8'h00);
    ex(cpsf_pkg::CPSF_OP_LOGIC, 8'h01, 8'h00, 8'h00, 4'h0);
    chk(status_o, 8'h19);
    @(posedge clk_i);
    rd_addr_i <= 8'h04;
    @(posedge clk_i);
    #1;
    chk(rd_hit_o, 1'b0);
    chk(rd_data_o, 8'h00);
  endtask
  // Cause flags follow sleep, expiry and watchdog clear
  task t_ev;
    ex(cpsf_pkg::CPSF_OP_NONE, 8'h00, 8'h00, 8'h00, 4'h2);
    chk(status_o, 8'h15);
    ex(cpsf_pkg::CPSF_OP_NONE, 8'h00, 8'h00, 8'h00, 4'h1);
    chk(status_o, 8'h05);
    ex(cpsf_pkg::CPSF_OP_NONE, 8'h00, 8'h00, 8'h00, 4'h4);
    chk(status_o, 8'h1D);
  endtask
  task stop_test;
    $display("checked %0d, n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Reset for two cycles, then the scenarios
  initial
  begin
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    chk(status_o, 8'h18);
    t_write;
    t_ev;
    t_rot;
    stop_test;
  end
endmodule
`default_nettype wire
